// file: core/tia_arbiter.sv
// trap and interrupt arbiter with vector push and pop sequencer
`timescale 1ns/1ps
module tia_arbiter
  import tia_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_done,
  input wire logic [15:0] instr_word,
  input wire tia_pkg::tia_instr_e instr_kind,
  input wire logic mapping_violation_flag,
  input wire logic bus_timeout_flag,
  input wire logic parity_fault_flag,
  input wire logic control_fault_flag,
  input wire logic [15:0] kernel_sp,
  input wire logic power_good_line,
  input wire logic irq_level_seven,
  input wire logic irq_level_six,
  input wire logic irq_level_five,
  input wire logic irq_level_four,
  input wire logic halt_request_line,
  input wire logic [15:0] irq_vector,
  input wire logic irq_vector_valid,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic [15:0] pc_in,
  input wire logic [15:0] psw_in,
  output logic abort_q,
  output logic busy_q,
  output logic iack_q,
  output logic [2:0] iack_level_q,
  output logic mem_req_q,
  output logic mem_we_q,
  output logic [15:0] mem_addr_q,
  output logic [15:0] mem_wdata_q,
  output logic [15:0] pc_q,
  output logic [15:0] processor_status_word,
  output logic load_q,
  output logic console_debug_mode,
  output logic [3:0] cause_q,
  output logic [7:0] user_byte_q,
  output logic conflict_q
);
  import tia_pkg::*;
  typedef enum logic [2:0] {
    S_RUN, S_IACK, S_PUSH_PS, S_PUSH_PC, S_RD_PC, S_RD_PS, S_POP_PC, S_POP_PS
  } tia_state_e;
  tia_state_e state_q;
  logic [15:0] sp_q, vec_q, save_pc_q, save_ps_q;
  logic power_drop_q, stack_low_q;
  logic [10:0] req, grant;
  logic any_req;
  logic [2:0] prio;
  logic [3:0] unmasked;
  logic abort_now;
  assign prio = processor_status_word[PSW_PRIO_LSB +: 3];
  // level n passes only while priority field is below n
  assign unmasked[3] = irq_level_seven && (prio < 3'd7);
  assign unmasked[2] = irq_level_six && (prio < 3'd6);
  assign unmasked[1] = irq_level_five && (prio < 3'd5);
  assign unmasked[0] = irq_level_four && (prio < 3'd4);
  assign abort_now = mapping_violation_flag | bus_timeout_flag
                   | parity_fault_flag;
  // abort faults act at once; the rest only at instruction end
  always_comb begin
    req = '0;
    req[0] = mapping_violation_flag;
    req[1] = bus_timeout_flag;
    req[2] = parity_fault_flag;
    if (instr_done) begin
      req[3] = processor_status_word[PSW_TRACE_BIT];
      req[4] = stack_low_q;
      req[5] = power_drop_q;
      req[9:6] = {unmasked[0], unmasked[1], unmasked[2], unmasked[3]};
      req[10] = halt_request_line;
    end
  end
  tia_prio_pick #(.N(11)) u_pick (
    .req(req),
    .grant(grant),
    .any(any_req)
  );
  // sticky stack and power causes, held until their trap is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stack_low_q <= 1'b0;
      power_drop_q <= 1'b0;
    end else begin
      if (state_q == S_RUN && instr_done && any_req && grant[4]) begin
        stack_low_q <= 1'b0;
      end
      if (state_q == S_RUN && instr_done && any_req && grant[5]) begin
        power_drop_q <= 1'b0;
      end
      if (kernel_sp < STACK_LIMIT) begin
        stack_low_q <= 1'b1;
      end
      if (!power_good_line) begin
        power_drop_q <= 1'b1;
      end
    end
  end
  // fault exclusivity watch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conflict_q <= 1'b0;
    end else begin
      conflict_q <= ($countones({control_fault_flag, mapping_violation_flag,
        bus_timeout_flag, parity_fault_flag}) > 1);
    end
  end
  // sequencer: arbitration, push, vector fetch, pop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= S_RUN;
      sp_q <= SP_RESET;
      vec_q <= '0;
      save_pc_q <= '0;
      save_ps_q <= '0;
      pc_q <= PC_RESET;
      processor_status_word <= PSW_RESET;
      abort_q <= 1'b0;
      busy_q <= 1'b0;
      iack_q <= 1'b0;
      iack_level_q <= '0;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= '0;
      mem_wdata_q <= '0;
      load_q <= 1'b0;
      console_debug_mode <= 1'b0;
      cause_q <= TIA_C_NONE;
      user_byte_q <= '0;
    end else begin
      abort_q <= 1'b0;
      load_q <= 1'b0;
      case (state_q)
        S_RUN: begin
          busy_q <= 1'b0;
          console_debug_mode <= 1'b0;
          mem_req_q <= 1'b0;
          save_pc_q <= pc_in;
          save_ps_q <= psw_in;
          processor_status_word <= psw_in;
          if (abort_now) begin
            abort_q <= 1'b1;
          end
          if (any_req && !grant[10]) begin
            busy_q <= 1'b1;
            if (grant[0]) begin
              vec_q <= VEC_MAPPING;
              cause_q <= TIA_C_MAPPING;
            end else if (grant[1]) begin
              vec_q <= VEC_BUS_TIMEOUT;
              cause_q <= TIA_C_TIMEOUT;
            end else if (grant[2]) begin
              vec_q <= VEC_PARITY;
              cause_q <= TIA_C_PARITY;
            end else if (grant[3]) begin
              vec_q <= VEC_TRACE;
              cause_q <= TIA_C_TRACE;
            end else if (grant[4]) begin
              vec_q <= VEC_STACK;
              cause_q <= TIA_C_STACK;
            end else begin
              vec_q <= VEC_POWER;
              cause_q <= TIA_C_POWER;
            end
            state_q <= S_PUSH_PS;
            if (|grant[9:6]) begin
              // device supplies the vector during acknowledge
              iack_q <= 1'b1;
              iack_level_q <= grant[6] ? 3'd7 : grant[7] ? 3'd6 :
                              grant[8] ? 3'd5 : 3'd4;
              cause_q <= grant[6] ? TIA_C_IRQ7 : grant[7] ? TIA_C_IRQ6 :
                         grant[8] ? TIA_C_IRQ5 : TIA_C_IRQ4;
              state_q <= S_IACK;
            end
          end else if (instr_done && instr_kind == TIA_INS_RET) begin
            busy_q <= 1'b1;
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b0;
            mem_addr_q <= sp_q;
            state_q <= S_POP_PC;
          end else if (instr_done && (instr_kind == TIA_INS_EMT ||
                       instr_kind == TIA_INS_TRAP)) begin
            busy_q <= 1'b1;
            user_byte_q <= instr_word[7:0];
            vec_q <= (instr_kind == TIA_INS_EMT) ? VEC_EMT : VEC_TRAP;
            cause_q <= (instr_kind == TIA_INS_EMT) ? TIA_C_EMT : TIA_C_TRAP;
            state_q <= S_PUSH_PS;
          end else if (any_req && grant[10]) begin
            console_debug_mode <= 1'b1;
            cause_q <= TIA_C_HALT;
          end
        end
        S_IACK: begin
          if (halt_request_line) begin
            console_debug_mode <= 1'b1;
          end
          if (irq_vector_valid) begin
            iack_q <= 1'b0;
            vec_q <= irq_vector;
            state_q <= S_PUSH_PS;
          end
        end
        S_PUSH_PS, S_PUSH_PC, S_RD_PC, S_RD_PS, S_POP_PC, S_POP_PS: begin
          if (halt_request_line) begin
            console_debug_mode <= 1'b1;
          end
          if (!mem_req_q) begin
            mem_req_q <= 1'b1;
            mem_we_q <= (state_q == S_PUSH_PS || state_q == S_PUSH_PC);
            case (state_q)
              S_PUSH_PS: begin
                mem_addr_q <= sp_q - WORD_STEP;
                mem_wdata_q <= save_ps_q;
              end
              S_PUSH_PC: begin
                mem_addr_q <= sp_q - WORD_STEP;
                mem_wdata_q <= save_pc_q;
              end
              S_RD_PC: mem_addr_q <= vec_q;
              S_RD_PS: mem_addr_q <= vec_q + WORD_STEP;
              default: mem_addr_q <= sp_q;
            endcase
          end else if (mem_ack) begin
            mem_req_q <= 1'b0;
            case (state_q)
              S_PUSH_PS: begin
                sp_q <= sp_q - WORD_STEP;
                state_q <= S_PUSH_PC;
              end
              S_PUSH_PC: begin
                sp_q <= sp_q - WORD_STEP;
                state_q <= S_RD_PC;
              end
              S_RD_PC: begin
                pc_q <= mem_rdata;
                state_q <= S_RD_PS;
              end
              S_RD_PS: begin
                processor_status_word <= mem_rdata;
                load_q <= 1'b1;
                state_q <= S_RUN;
              end
              S_POP_PC: begin
                pc_q <= mem_rdata;
                sp_q <= sp_q + WORD_STEP;
                state_q <= S_POP_PS;
              end
              default: begin
                processor_status_word <= mem_rdata;
                sp_q <= sp_q + WORD_STEP;
                load_q <= 1'b1;
                state_q <= S_RUN;
              end
            endcase
          end
        end
        default: state_q <= S_RUN;
      endcase
    end
  end
  // checks
  chk_mask_seven: assert property (@(posedge clk) disable iff (rst)
    (prio == 3'd7) |-> !(|req[9:6]))
    else $error("interrupt passed at priority seven");
  chk_vec_pc_addr: assert property (@(posedge clk) disable iff (rst)
    (state_q == S_RD_PC && mem_req_q) |-> mem_addr_q == vec_q)
    else $error("pc not read at vector");
  chk_vec_ps_addr: assert property (@(posedge clk) disable iff (rst)
    (state_q == S_RD_PS && mem_req_q) |-> mem_addr_q == vec_q + WORD_STEP)
    else $error("status not read at vector plus two");
  chk_abort_pulse: assert property (@(posedge clk) disable iff (rst)
    (state_q == S_RUN && abort_now) |=> abort_q)
    else $error("abort missing on fault");
  chk_timeout_vec: assert property (@(posedge clk) disable iff (rst)
    (state_q == S_RUN && bus_timeout_flag && !mapping_violation_flag)
    |=> vec_q == VEC_BUS_TIMEOUT)
    else $error("timeout vector wrong");
  chk_parity_vec: assert property (@(posedge clk) disable iff (rst)
    (state_q == S_RUN && parity_fault_flag && !mapping_violation_flag
     && !bus_timeout_flag) |=> vec_q == VEC_PARITY)
    else $error("parity vector wrong");
  chk_mid_instr: assert property (@(posedge clk) disable iff (rst)
    !instr_done |-> !(|req[10:3]))
    else $error("end condition sampled mid instruction");
  chk_power_sticky: assert property (@(posedge clk) disable iff (rst)
    !power_good_line |=> power_drop_q)
    else $error("power drop not held");
  chk_push_order: assert property (@(posedge clk) disable iff (rst)
    (state_q == S_PUSH_PS && mem_req_q && mem_ack) |=> state_q == S_PUSH_PC)
    else $error("push order wrong");
  chk_halt_service: assert property (@(posedge clk) disable iff (rst)
    (state_q != S_RUN && halt_request_line) |=> console_debug_mode)
    else $error("halt in service ignored");
  cov_irq: cover property (@(posedge clk) disable iff (rst) iack_q);
  cov_ret: cover property (@(posedge clk) disable iff (rst)
    state_q == S_POP_PS && mem_ack);
  cov_trap: cover property (@(posedge clk) disable iff (rst)
    state_q == S_RD_PS && load_q == 1'b0 && mem_ack);
endmodule // tia_arbiter

// file: core/tia_pkg.sv
// shared constants for the trap and interrupt arbiter
package tia_pkg;
  localparam int WORD_W = 16;
  // vector addresses (octal as printed)
  localparam logic [15:0] VEC_MAPPING = 16'o250;
  localparam logic [15:0] VEC_BUS_TIMEOUT = 16'o4;
  localparam logic [15:0] VEC_PARITY = 16'o114;
  localparam logic [15:0] VEC_TRACE = 16'o14;
  localparam logic [15:0] VEC_STACK = 16'o4;
  localparam logic [15:0] VEC_POWER = 16'o24;
  localparam logic [15:0] VEC_RESERVED_INSTR = 16'o10;
  localparam logic [15:0] VEC_EMT = 16'o30;
  localparam logic [15:0] VEC_TRAP = 16'o34;
  localparam logic [15:0] STACK_LIMIT = 16'o400;
  localparam logic [15:0] PSW_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'o1000;
  localparam int PSW_TRACE_BIT = 4;
  localparam int PSW_PRIO_LSB = 5;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  // causes in service order, highest first, except that EMT and TRAP are served ahead of HALT
  typedef enum logic [3:0] {
    TIA_C_NONE, TIA_C_MAPPING, TIA_C_TIMEOUT, TIA_C_PARITY, TIA_C_TRACE,
    TIA_C_STACK, TIA_C_POWER, TIA_C_IRQ7, TIA_C_IRQ6, TIA_C_IRQ5,
    TIA_C_IRQ4, TIA_C_HALT, TIA_C_EMT, TIA_C_TRAP
  } tia_cause_e;
  typedef enum logic [1:0] {
    TIA_INS_NONE, TIA_INS_EMT, TIA_INS_TRAP, TIA_INS_RET
  } tia_instr_e;
endpackage

// file: core/tia_prio_pick.sv
// fixed priority picker over pending causes
`timescale 1ns/1ps
module tia_prio_pick #(
  parameter int N = 11
) (
  input wire logic [N-1:0] req,
  output logic [N-1:0] grant,
  output logic any
);
  // refuse an empty request vector at elaboration
  if (N < 1) begin : g_bad_n
    $error("tia_prio_pick: N must be at least one");
  end
  // bit 0 is the highest priority
  always_comb begin
    grant = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        grant = '0;
        grant[i] = 1'b1;
      end
    end
    any = |req;
  end
endmodule // tia_prio_pick

// file: bench/tia_dev_model.sv
// bus-side model: interrupting devices and a word memory
`timescale 1ns/1ps
module tia_dev_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] lat,
  input wire logic [3:0] raise,
  input wire logic clr,
  input wire logic iack_q,
  input wire logic [2:0] iack_level_q,
  input wire logic mem_req_q,
  input wire logic mem_we_q,
  input wire logic [15:0] mem_addr_q,
  input wire logic [15:0] mem_wdata_q,
  output logic irq_level_seven,
  output logic irq_level_six,
  output logic irq_level_five,
  output logic irq_level_four,
  output logic [15:0] irq_vector,
  output logic irq_vector_valid,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [15:0] mem [0:511];
  logic [3:0] pend_q;
  logic [1:0] cnt_q;
  logic [1:0] vcnt_q;
  // every word starts as its own address scrambled
  initial for (int i = 0; i < 512; i++) mem[i] = 16'(2 * i) ^ 16'ha5c3;
  // requests are levels held until acknowledged or cleared by clr
  assign {irq_level_seven, irq_level_six} = pend_q[3:2];
  assign {irq_level_five, irq_level_four} = pend_q[1:0];
  // device answers acknowledge with its vector after lat cycles
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q <= 4'h0;
      vcnt_q <= 2'h0;
      irq_vector <= 16'h0;
      irq_vector_valid <= 1'b0;
    end else begin
      pend_q <= (clr ? 4'h0 : pend_q) | raise;
      if (iack_q && !irq_vector_valid) begin
        if (vcnt_q == lat) begin
          irq_vector_valid <= 1'b1;
          irq_vector <= 16'o300 + {11'h0, iack_level_q, 2'b00};
          pend_q[iack_level_q - 3'h4] <= 1'b0;
          vcnt_q <= 2'h0;
        end else
          vcnt_q <= vcnt_q + 2'h1;
      end else if (!iack_q) begin
        irq_vector_valid <= 1'b0;
        irq_vector <= ~irq_vector; // released lines show no stale value
      end
    end
  end
  // memory acks one request after lat cycles, data valid with ack only
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      cnt_q <= 2'h0;
      mem_rdata <= 16'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req_q && !mem_ack) begin
        if (cnt_q == lat) begin
          mem_ack <= 1'b1;
          cnt_q <= 2'h0;
          if (mem_we_q)
            mem[mem_addr_q[9:1]] <= mem_wdata_q;
          else
            mem_rdata <= mem[mem_addr_q[9:1]];
        end else
          cnt_q <= cnt_q + 2'h1;
      end
    end
  end
endmodule // tia_dev_model

// file: bench/tia_arbiter_tb.sv
// self-checking bench for the trap and interrupt arbiter
`timescale 1ns/1ps
module tia_arbiter_tb;
  import tia_pkg::*;
  localparam logic [15:0] PAT = 16'ha5c3;
  logic clk, rst, instr_done, mem_ack, irq_vector_valid, clr, load_q;
  logic mapping_violation_flag, bus_timeout_flag, parity_fault_flag;
  logic control_fault_flag, power_good_line, halt_request_line;
  logic irq_level_seven, irq_level_six, irq_level_five, irq_level_four;
  logic [15:0] instr_word, kernel_sp, irq_vector, mem_rdata, pc_in, psw_in;
  logic [15:0] mem_addr_q, mem_wdata_q, pc_q, processor_status_word, sv_pc;
  logic [15:0] sv_ps, w;
  logic abort_q, busy_q, iack_q, mem_req_q, mem_we_q, console_debug_mode;
  logic conflict_q;
  logic [2:0] iack_level_q;
  logic [3:0] cause_q, raise;
  logic [7:0] user_byte_q;
  logic [1:0] lat;
  logic [35:0] e;
  tia_instr_e instr_kind;
  logic [35:0] exp_q[$];
  int n_errors = 0;
  int comparisons = 0;
  int i, k;
  tia_cause_e fc[3] = '{TIA_C_MAPPING, TIA_C_TIMEOUT, TIA_C_PARITY};
  logic [15:0] fv[3] = '{VEC_MAPPING, VEC_BUS_TIMEOUT, VEC_PARITY};

  tia_arbiter uut (.*);
  tia_dev_model dev (.*);

  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic want(input tia_cause_e c, input logic [15:0] v);
    exp_q.push_back({c, v ^ PAT, (v + 16'h2) ^ PAT});
  endtask
  // one instruction ends with the given kind
  task automatic fin(input tia_instr_e kd, input logic [15:0] wd);
    instr_done = 1'b1;
    instr_kind = kd;
    instr_word = wd;
    lat = 2'($urandom);
    tick;
    instr_done = 1'b0;
    instr_kind = TIA_INS_NONE;
  endtask
  // bounded wait for one service sequence to start and end
  task automatic settle;
    int n, m;
    for (n = 0; n < 6 && busy_q !== 1'b1; n++) tick;
    for (m = 0; m < 400 && busy_q !== 1'b0; m++) tick;
    if (n == 6 || m == 400) begin
      n_errors++;
      $display("ERROR t=%0t hang %h %h", $time, n, m);
      close_out;
    end
  endtask
  task automatic quiet;
    repeat (3) tick;
    cmp({15'h0, busy_q}, 16'h0);
  endtask
  task automatic fault(input int f);
    int n;
    mapping_violation_flag = (f == 0);
    bus_timeout_flag = (f == 1);
    parity_fault_flag = (f == 2);
    control_fault_flag = (f == 2); // last pass reports two faults at once
    tick;
    cmp({15'h0, conflict_q}, {15'h0, 1'(f == 2)});
    {mapping_violation_flag, bus_timeout_flag, parity_fault_flag} = 3'h0;
    control_fault_flag = 1'b0;
    for (n = 0; n < 4 && abort_q !== 1'b1; n++) tick;
    cmp({15'h0, abort_q}, 16'h1);
    settle;
  endtask

  // every load is matched against the oldest note
  always @(posedge clk) begin
    if (load_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("ERROR t=%0t load %h exp %h", $time, pc_q, 16'h0);
      end else begin
        e = exp_q.pop_front();
        cmp(pc_q, e[31:16]);
        cmp(processor_status_word, e[15:0]);
        if (e[35:32] != 4'hf) cmp({12'h0, cause_q}, {12'h0, e[35:32]});
      end
    end
  end

  // main sequence
  initial begin
    k = $urandom(36402);
    {rst, instr_done, clr, halt_request_line, control_fault_flag} = 5'h10;
    {mapping_violation_flag, bus_timeout_flag, parity_fault_flag} = 3'h0;
    {instr_word, pc_in, psw_in, raise, lat} = '0;
    instr_kind = TIA_INS_NONE;
    power_good_line = 1'b1;
    kernel_sp = SP_RESET;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    tick;
    for (i = 0; i < 3; i++) begin
      want(fc[i], fv[i]);
      fault(i);
    end
    psw_in = 16'h00f0;
    power_good_line = 1'b0;
    raise = 4'h8;
    tick;
    power_good_line = 1'b1;
    raise = 4'h0;
    quiet;
    want(TIA_C_TRACE, VEC_TRACE);
    fin(TIA_INS_NONE, 16'h0);
    settle;
    psw_in = 16'h00e0;
    tick;
    want(TIA_C_POWER, VEC_POWER);
    fin(TIA_INS_NONE, 16'h0);
    settle;
    kernel_sp = 16'o376;
    tick;
    kernel_sp = SP_RESET;
    quiet;
    want(TIA_C_STACK, VEC_STACK);
    fin(TIA_INS_NONE, 16'h0);
    settle;
    fin(TIA_INS_NONE, 16'h0);
    quiet;
    psw_in = 16'h0;
    tick;
    for (k = 7; k >= 4; k--) begin
      raise = (k == 7) ? 4'hf : 4'h0;
      want(tia_cause_e'(14 - k), 16'o300 + 16'(4 * k));
      fin(TIA_INS_NONE, 16'h0);
      raise = 4'h0;
      settle;
    end
    for (k = 4; k < 8; k++) begin
      for (i = 0; i < 2; i++) begin
        psw_in = {8'($urandom), 3'(k - 1 + i), 5'h0};
        raise = 4'(1 << (k - 4));
        tick;
        raise = 4'h0;
        if (i == 0) begin
          want(tia_cause_e'(14 - k), 16'o300 + 16'(4 * k));
          fin(TIA_INS_NONE, 16'h0);
          settle;
        end else begin
          fin(TIA_INS_NONE, 16'h0);
          quiet;
          clr = 1'b1;
          tick;
          clr = 1'b0;
        end
      end
    end
    halt_request_line = 1'b1;
    fin(TIA_INS_NONE, 16'h0);
    for (i = 0; i < 4 && console_debug_mode !== 1'b1; i++) tick;
    cmp({15'h0, console_debug_mode}, 16'h1);
    halt_request_line = 1'b0;
    repeat (3) tick;
    for (k = 0; k < 2; k++) begin
      sv_pc = 16'($urandom);
      sv_ps = 16'($urandom) & 16'hffef;
      pc_in = sv_pc;
      psw_in = sv_ps;
      w = {8'h88, 8'($urandom)};
      want(k ? TIA_C_TRAP : TIA_C_EMT, k ? VEC_TRAP : VEC_EMT);
      halt_request_line = 1'(k); // second pass halts during service
      fin(k ? TIA_INS_TRAP : TIA_INS_EMT, w);
      tick;
      cmp({15'h0, console_debug_mode}, {15'h0, 1'(k)});
      halt_request_line = 1'b0;
      settle;
      cmp({8'h0, user_byte_q}, {8'h0, w[7:0]});
      exp_q.push_back({4'hf, sv_pc, sv_ps});
      psw_in = 16'h0;
      fin(TIA_INS_RET, 16'h0);
      settle;
    end
    repeat (3) tick;
    cmp(16'(exp_q.size()), 16'h0);
    close_out;
  end
endmodule // tia_arbiter_tb
